// ### hw/rdap_regs.svh
`ifndef RDAP_REGS_SVH
`define RDAP_REGS_SVH

// Clock and device timing, in ns; RAS_CYC in clocks
`define CLK_NS 40
`define T_RAS_NS 120
`define T_RTP_NS 50
`define T_RP_NS 60
`define RAS_CYC ((`T_RAS_NS + `CLK_NS - 1) / `CLK_NS)

// Controller register offsets
`define REG_CFG 8'h00
`define REG_TIMING 8'h04
`define REG_CMD 8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA 8'h10

// Field positions
`define CFG_AL_LSB 0
`define CFG_CL_LSB 4
`define CFG_BL8_BIT 8
`define TIM_RAS_LSB 0
`define TIM_RTP_LSB 8
`define TIM_RP_LSB 16
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 2
`define CMD_AP_BIT 5
`define CMD_ADDR_LSB 8
`define ST_PEND_BIT 0
`define ST_RDV_BIT 1
`define ST_OPEN_LSB 8
`define ST_APP_LSB 16

// Reset values
`define CFG_RST 32'h00000031
`define TIMING_RST 32'h003c3278

`endif

// ### hw/rdap_pkg.sv
package rdap_pkg;
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4
	} cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_HOLD = 2'b10
	} ctrl_state_t;
endpackage

// ### hw/ddr_link_if.sv
`timescale 1ns/10ps
interface ddr_link_if;
	import rdap_pkg::*;
	cmd_t cmd;
	logic [2:0] bank;
	logic [13:0] addr;
	logic autoPrechargeSelectBit;
	logic [15:0] dqOut;
	logic dqOeLo_n;
	logic dqOeHi_n;
	logic lowerByteStrobe;
	logic upperByteStrobe;

	modport ctrl (
		output cmd, bank, addr, autoPrechargeSelectBit,
		input dqOut, dqOeLo_n, dqOeHi_n, lowerByteStrobe, upperByteStrobe
	);
	modport mem (
		input cmd, bank, addr, autoPrechargeSelectBit,
		output dqOut, dqOeLo_n, dqOeHi_n, lowerByteStrobe, upperByteStrobe
	);
endinterface

// ### hw/rdap_mem_end.sv
`timescale 1ns/10ps
`include "rdap_regs.svh"
module rdap_mem_end import rdap_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Command and data link
	ddr_link_if.mem link,
	// Latency and burst setup
	input wire logic [2:0] additiveLatency,
	input wire logic [2:0] casLatency,
	input wire logic burstLength8,
	// Bank status
	output logic [7:0] bankOpen,
	output logic [7:0] prechargeStart,
	output logic cmdError
);
	localparam logic signed [10:0] CLK = 11'(`CLK_NS);
	localparam logic signed [10:0] READ_TO_PRECHARGE_TIME = 11'(`T_RTP_NS);
	localparam logic signed [10:0] PRECHARGE_PERIOD = 11'(`T_RP_NS);
	localparam logic [7:0] RAS = 8'(`RAS_CYC);

	logic [7:0] apPend_q, apLate_q;
	logic [3:0] apCnt_q [8];
	logic [7:0] rasCnt_q [8];
	logic signed [10:0] rtpNs_q [8];
	logic signed [10:0] rpNs_q [8];
	logic [7:0] sel, apGo, rtpPush;
	logic signed [10:0] rtpNext [8];
	logic [3:0] prefetch, apLoad;
	logic isRead;

	////////////////////////////////////////////////////////////////
	// Edge of the last 4-bit prefetch, and the nominal start
	always_comb begin
		prefetch = {1'b0, additiveLatency} + (burstLength8 ? 4'h2 : 4'h0);
		apLoad = {1'b0, additiveLatency} + (burstLength8 ? 4'h4 : 4'h2);
		if (apLoad < prefetch + 4'h2) begin
			apLoad = prefetch + 4'h2;
		end
		apLoad = apLoad - 4'h1;
		sel = 8'h01 << link.bank;
		isRead = link.cmd == CMD_RD && bankOpen[link.bank] && !apPend_q[link.bank];
	end

	// Per-bank start test; ns residue kept so precharge_period runs from the true moment
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			rtpNext[b] = rtpNs_q[b] - CLK;
			apGo[b] = apPend_q[b] && apCnt_q[b] == 4'h0 && rasCnt_q[b] >= RAS && rtpNext[b] <= 0;
			rtpPush[b] = apLate_q[b] && rasCnt_q[b] > RAS && rtpNs_q[b] > 0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bank timing state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bankOpen <= 8'h00;
			apPend_q <= 8'h00;
			apLate_q <= 8'h00;
			prechargeStart <= 8'h00;
			for (int b = 0; b < 8; b++) begin
				apCnt_q[b] <= 4'h0;
				rasCnt_q[b] <= 8'h00;
				rtpNs_q[b] <= 11'sh000;
				rpNs_q[b] <= 11'sh000;
			end
		end else begin
			for (int b = 0; b < 8; b++) begin
				prechargeStart[b] <= 1'b0;
				apLate_q[b] <= apPend_q[b] && apCnt_q[b] == 4'h0 && !apGo[b];
				if (rasCnt_q[b] != 8'hff) begin
					rasCnt_q[b] <= rasCnt_q[b] + 8'h01;
				end
				if (rtpNs_q[b] > 0) begin
					rtpNs_q[b] <= rtpNext[b];
				end
				if (rpNs_q[b] > 0) begin
					rpNs_q[b] <= rpNs_q[b] - CLK;
				end
				if (apCnt_q[b] != 4'h0) begin
					apCnt_q[b] <= apCnt_q[b] - 4'h1;
				end
				if (sel[b] && link.cmd == CMD_ACT && !bankOpen[b] && rpNs_q[b] <= CLK) begin
					bankOpen[b] <= 1'b1;
					rasCnt_q[b] <= 8'h01;
				end
				// Time to the final prefetch plus read_to_precharge_time, counted from this edge
				if (sel[b] && isRead) begin
					rtpNs_q[b] <= READ_TO_PRECHARGE_TIME + CLK * 11'(prefetch);
					if (link.autoPrechargeSelectBit) begin
						apPend_q[b] <= 1'b1;
						apCnt_q[b] <= apLoad;
					end
				end
				if (sel[b] && link.cmd == CMD_PRE && !apPend_q[b]) begin
					bankOpen[b] <= 1'b0;
					rpNs_q[b] <= PRECHARGE_PERIOD;
				end
				// Internal precharge; other banks keep running
				if (apGo[b]) begin
					apPend_q[b] <= 1'b0;
					bankOpen[b] <= 1'b0;
					prechargeStart[b] <= 1'b1;
					rpNs_q[b] <= rtpPush[b] ? PRECHARGE_PERIOD + rtpNext[b] : PRECHARGE_PERIOD;
				end
			end
		end
	end

	// Flag commands that break bank state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmdError <= 1'b0;
		end else begin
			unique case (link.cmd)
				CMD_ACT: cmdError <= bankOpen[link.bank] || rpNs_q[link.bank] > CLK;
				CMD_RD, CMD_WR: cmdError <= !bankOpen[link.bank] || apPend_q[link.bank];
				default: cmdError <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, one beat per clock; a beat stands for an element pair
	logic [15:0] rdShift_q;
	logic [2:0] bankPipe_q [16];
	logic [2:0] beats_q, beatIdx_q, burstBank_q;
	logic [3:0] readLat;
	logic burstGo;

	always_comb begin
		readLat = {1'b0, additiveLatency} + {1'b0, casLatency};
		burstGo = rdShift_q[readLat - 4'h1];
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdShift_q <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				bankPipe_q[i] <= 3'h0;
			end
		end else begin
			rdShift_q <= {rdShift_q[14:0], isRead};
			bankPipe_q[0] <= link.bank;
			for (int i = 1; i < 16; i++) begin
				bankPipe_q[i] <= bankPipe_q[i - 1];
			end
		end
	end

	// Concatenated bursts: a new start overrides the tail
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			beats_q <= 3'h0;
			beatIdx_q <= 3'h0;
			burstBank_q <= 3'h0;
			link.dqOut <= 16'h0000;
			link.dqOeLo_n <= 1'b1;
			link.dqOeHi_n <= 1'b1;
			link.lowerByteStrobe <= 1'b0;
			link.upperByteStrobe <= 1'b0;
		end else begin
			if (burstGo) begin
				beats_q <= burstLength8 ? 3'h3 : 3'h1;
				beatIdx_q <= 3'h1;
				burstBank_q <= bankPipe_q[readLat - 4'h1];
				link.dqOut <= {bankPipe_q[readLat - 4'h1], 10'h000, 3'h0};
			end else if (beats_q != 3'h0) begin
				beats_q <= beats_q - 3'h1;
				beatIdx_q <= beatIdx_q + 3'h1;
				link.dqOut <= {burstBank_q, 10'h000, beatIdx_q};
			end
			// Each byte lane has its own strobe and enable
			link.dqOeLo_n <= !(burstGo || beats_q != 3'h0);
			link.dqOeHi_n <= !(burstGo || beats_q != 3'h0);
			link.lowerByteStrobe <= (burstGo || beats_q != 3'h0) && !link.lowerByteStrobe;
			link.upperByteStrobe <= (burstGo || beats_q != 3'h0) && !link.upperByteStrobe;
		end
	end
endmodule

// ### hw/rdap_ctrl_end.sv
`timescale 1ns/10ps
`include "rdap_regs.svh"
module rdap_ctrl_end import rdap_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory link
	ddr_link_if.ctrl link
);
	logic [31:0] cfg_q, timing_q, rdData_q;
	ctrl_state_t state_q;
	cmd_t op_q, cmd_q;
	logic [2:0] pendBank_q, bank_q;
	logic [13:0] pendAddr_q, addr_q;
	logic pendAp_q, ap_q, rdValid_q;
	logic [7:0] open_q, apOpen_q;
	logic [7:0] preWait_q [8];
	logic [7:0] actWait_q [8];
	logic [7:0] rdGap_q, wrGap_q, anyGap_q, rdWait_q;
	logic [2:0] gapBank_q;

	// Clocks for a time in ns, rounded up
	function automatic logic [7:0] nsToCyc(input logic [9:0] ns);
		nsToCyc = 8'((ns + 10'(`CLK_NS - 1)) / 10'(`CLK_NS));
	endfunction

	// Load value for a countdown that frees the command n clocks later
	function automatic logic [7:0] waitLoad(input logic [7:0] n);
		waitLoad = (n == 8'h00) ? 8'h00 : n - 8'h01;
	endfunction

	logic [7:0] al, halfBl, rtpCyc, rpCyc, actLoad, preLoad;
	logic [3:0] readLat;
	logic legal, accessPh, wrEn, rdEn, cmdBusy, capture, issue;

	////////////////////////////////////////////////////////////////
	// Derived timing from the configuration registers
	always_comb begin
		al = {5'h00, cfg_q[`CFG_AL_LSB +: 3]};
		halfBl = cfg_q[`CFG_BL8_BIT] ? 8'h04 : 8'h02;
		readLat = {1'b0, cfg_q[`CFG_AL_LSB +: 3]} + {1'b0, cfg_q[`CFG_CL_LSB +: 3]};
		rtpCyc = nsToCyc({2'b00, timing_q[`TIM_RTP_LSB +: 8]});
		rpCyc = nsToCyc({2'b00, timing_q[`TIM_RP_LSB +: 8]});
		actLoad = al + (cfg_q[`CFG_BL8_BIT] ? 8'h02 : 8'h00)
			+ nsToCyc({2'b00, timing_q[`TIM_RTP_LSB +: 8]} + {2'b00, timing_q[`TIM_RP_LSB +: 8]});
		// Short read_to_precharge_time on a slow clock: precharge still waits for its nominal edge
		if (actLoad < al + halfBl + rpCyc) begin
			actLoad = al + halfBl + rpCyc;
		end
		preLoad = al + halfBl - 8'h02 + ((rtpCyc > 8'h02) ? rtpCyc : 8'h02);
	end

	// Can the held command go out on this edge
	always_comb begin
		legal = 1'b0;
		unique case (op_q)
			CMD_ACT: legal = !open_q[pendBank_q] && actWait_q[pendBank_q] == 8'h00;
			CMD_RD: legal = open_q[pendBank_q] && !apOpen_q[pendBank_q];
			CMD_WR: legal = open_q[pendBank_q] && !apOpen_q[pendBank_q];
			CMD_PRE: legal = open_q[pendBank_q] && !apOpen_q[pendBank_q] && preWait_q[pendBank_q] == 8'h00;
			default: legal = 1'b1;
		endcase
		// Other banks stay usable during an auto precharge
		if (pendBank_q != gapBank_q) begin
			unique case (op_q)
				CMD_RD: legal = legal && rdGap_q == 8'h00;
				CMD_WR: legal = legal && wrGap_q == 8'h00;
				default: legal = legal && anyGap_q == 8'h00;
			endcase
		end
		issue = state_q == ST_HOLD && legal;
	end

	////////////////////////////////////////////////////////////////
	// APB decode; one wait state, longer for a command write while a command is held
	always_comb begin
		accessPh = psel && penable && !pready;
		cmdBusy = pwrite && paddr == `REG_CMD && state_q != ST_IDLE;
		wrEn = psel && penable && pready && pwrite;
		rdEn = psel && penable && pready && !pwrite;
		capture = rdWait_q == 8'h01 && !link.dqOeLo_n;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= accessPh && !cmdBusy;
			pslverr <= accessPh && !cmdBusy && paddr > `REG_RDATA;
			unique case (paddr)
				`REG_CFG: prdata <= cfg_q;
				`REG_TIMING: prdata <= timing_q;
				`REG_STATUS: prdata <= {8'h00, apOpen_q, open_q, 6'h00, rdValid_q, state_q == ST_HOLD};
				`REG_RDATA: prdata <= rdData_q;
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_q <= `CFG_RST;
			timing_q <= `TIMING_RST;
		end else if (wrEn && paddr == `REG_CFG) begin
			cfg_q <= {23'h000000, pwdata[8], 1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
		end else if (wrEn && paddr == `REG_TIMING) begin
			timing_q <= {8'h00, pwdata[23:0]};
		end
	end

	// Captured read word; a new capture wins over the clearing read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdData_q <= 32'h00000000;
			rdValid_q <= 1'b0;
		end else if (capture) begin
			rdData_q <= {16'h0000, link.dqOut};
			rdValid_q <= 1'b1;
		end else if (rdEn && paddr == `REG_RDATA) begin
			rdValid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command holding and issue
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			op_q <= CMD_NOP;
			pendBank_q <= 3'h0;
			pendAddr_q <= 14'h0000;
			pendAp_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: if (wrEn && paddr == `REG_CMD) begin
					op_q <= cmd_t'({1'b0, pwdata[`CMD_OP_LSB +: 2]} + 3'h1);
					pendBank_q <= pwdata[`CMD_BANK_LSB +: 3];
					pendAp_q <= pwdata[`CMD_AP_BIT];
					pendAddr_q <= pwdata[`CMD_ADDR_LSB +: 14];
					state_q <= ST_HOLD;
				end
				ST_HOLD: if (issue) begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Link drive, one clock per command
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmd_q <= CMD_NOP;
			bank_q <= 3'h0;
			addr_q <= 14'h0000;
			ap_q <= 1'b0;
		end else begin
			cmd_q <= issue ? op_q : CMD_NOP;
			if (issue) begin
				bank_q <= pendBank_q;
				addr_q <= pendAddr_q;
				ap_q <= pendAp_q && op_q == CMD_RD;
			end
		end
	end

	assign link.cmd = cmd_q;
	assign link.bank = bank_q;
	assign link.addr = addr_q;
	assign link.autoPrechargeSelectBit = ap_q;

	////////////////////////////////////////////////////////////////
	// Per-bank countdowns; zero means the command is free
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			open_q <= 8'h00;
			apOpen_q <= 8'h00;
			for (int b = 0; b < 8; b++) begin
				preWait_q[b] <= 8'h00;
				actWait_q[b] <= 8'h00;
			end
		end else begin
			for (int b = 0; b < 8; b++) begin
				if (preWait_q[b] != 8'h00) begin
					preWait_q[b] <= preWait_q[b] - 8'h01;
				end
				if (actWait_q[b] != 8'h00) begin
					actWait_q[b] <= actWait_q[b] - 8'h01;
				end else begin
					apOpen_q[b] <= 1'b0;
				end
				if (issue && pendBank_q == 3'(b)) begin
					unique case (op_q)
						CMD_ACT: begin
							open_q[b] <= 1'b1;
							preWait_q[b] <= waitLoad(nsToCyc({2'b00, timing_q[`TIM_RAS_LSB +: 8]}));
						end
						CMD_RD: if (pendAp_q) begin
							open_q[b] <= 1'b0;
							apOpen_q[b] <= 1'b1;
							actWait_q[b] <= waitLoad(actLoad);
						end else if (waitLoad(preLoad) > preWait_q[b]) begin
							preWait_q[b] <= waitLoad(preLoad);
						end
						CMD_PRE: begin
							open_q[b] <= 1'b0;
							actWait_q[b] <= waitLoad(nsToCyc({2'b00, timing_q[`TIM_RP_LSB +: 8]}));
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Spacing to other banks after a read with auto precharge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdGap_q <= 8'h00;
			wrGap_q <= 8'h00;
			anyGap_q <= 8'h00;
			gapBank_q <= 3'h0;
		end else if (issue && op_q == CMD_RD && pendAp_q) begin
			gapBank_q <= pendBank_q;
			rdGap_q <= waitLoad(halfBl);
			wrGap_q <= waitLoad(halfBl + 8'h02);
			anyGap_q <= waitLoad(8'h01);
		end else begin
			rdGap_q <= (rdGap_q != 8'h00) ? rdGap_q - 8'h01 : 8'h00;
			wrGap_q <= (wrGap_q != 8'h00) ? wrGap_q - 8'h01 : 8'h00;
			anyGap_q <= (anyGap_q != 8'h00) ? anyGap_q - 8'h01 : 8'h00;
		end
	end

	// First read beat arrives read latency after the device takes the read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdWait_q <= 8'h00;
		end else if (issue && op_q == CMD_RD) begin
			rdWait_q <= {4'h0, readLat} + 8'h02;
		end else if (rdWait_q != 8'h00) begin
			rdWait_q <= rdWait_q - 8'h01;
		end
	end
endmodule

// ### sim/rdap_link_monitor.sv
`timescale 1ns/10ps
`include "rdap_regs.svh"
module rdap_link_monitor import rdap_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Link
	input wire cmd_t cmd,
	input wire logic [2:0] bank,
	input wire logic autoPrechargeSelectBit,
	input wire logic [15:0] dqOut,
	input wire logic dqOeLo_n,
	input wire logic dqOeHi_n,
	input wire logic lowerByteStrobe,
	input wire logic upperByteStrobe,
	// Device side
	input wire logic burstLength8,
	input wire logic [7:0] prechargeStart,
	input wire logic cmdError
);
	// Bench keeps additive latency 1 and cas latency 3
	localparam int AL = 1;
	localparam int DQD = 5;
	localparam int PMIN = 3;
	localparam int PMAX = 9;
	localparam int APC = (`T_RTP_NS + `T_RP_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int RTPC = (`T_RTP_NS + `CLK_NS - 1) / `CLK_NS > 2 ? (`T_RTP_NS + `CLK_NS - 1) / `CLK_NS : 2;
	logic [2:0] apBank_q, rdBank_q, actBank_q;
	logic [7:0] apAge_q, rdAge_q, actAge_q;
	logic [3:0] half;
	assign half = burstLength8 ? 4'h4 : 4'h2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	// Ages since last commands; saturate so stale history never fires
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{apAge_q, rdAge_q, actAge_q} <= 24'hffffff;
			{apBank_q, rdBank_q, actBank_q} <= 9'h0;
		end else begin
			apAge_q <= apAge_q + {7'h0, apAge_q != 8'hff};
			rdAge_q <= rdAge_q + {7'h0, rdAge_q != 8'hff};
			actAge_q <= actAge_q + {7'h0, actAge_q != 8'hff};
			if (cmd == CMD_RD && autoPrechargeSelectBit) begin
				{apAge_q, apBank_q} <= {8'h0, bank};
			end
			if (cmd == CMD_RD && !autoPrechargeSelectBit) begin
				{rdAge_q, rdBank_q} <= {8'h0, bank};
			end
			if (cmd == CMD_ACT) begin
				{actAge_q, actBank_q} <= {8'h0, bank};
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Command spacing kept by the controller
	property p_act_gap;
		cmd == CMD_ACT && bank == apBank_q |-> apAge_q >= AL + APC - 1 + (burstLength8 ? 2 : 0);
	endproperty
	a_act_gap: assert property (p_act_gap) else $error("ACT too soon");
	property p_other;
		(cmd == CMD_RD || cmd == CMD_WR) && bank != apBank_q |-> apAge_q >= half - 1 + (cmd == CMD_WR ? 2 : 0);
	endproperty
	a_other: assert property (p_other) else $error("Other bank too soon");
	property p_pre_gap;
		cmd == CMD_PRE && bank == rdBank_q |-> rdAge_q >= AL + half - 2 + RTPC - 1;
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("PRE too soon after read");
	property p_ras;
		cmd == CMD_PRE && bank == actBank_q |-> actAge_q >= `RAS_CYC - 1;
	endproperty
	a_ras: assert property (p_ras) else $error("PRE before row active time");
	// Internal precharge placement; a slow start would miss the window
	property p_pc_early;
		|(prechargeStart & (8'h1 << apBank_q)) |-> apAge_q >= AL + half;
	endproperty
	a_pc_early: assert property (p_pc_early) else $error("Precharge too early");
	property p_pc_start;
		cmd == CMD_RD && autoPrechargeSelectBit |-> ##[PMIN:PMAX] |prechargeStart;
	endproperty
	a_pc_start: assert property (p_pc_start) else $error("Precharge never started");
	// Read data and strobes
	property p_dq;
		cmd == CMD_RD |-> ##DQD !dqOeLo_n && dqOut == {$past(bank, DQD), 13'h0} ##1 dqOut[12:0] == 13'h1;
	endproperty
	a_dq: assert property (p_dq) else $error("Read data late or wrong");
	property p_strb;
		$fell(dqOeLo_n) |-> lowerByteStrobe && upperByteStrobe;
	endproperty
	a_strb: assert property (p_strb) else $error("Strobe not high at start");
	property p_tog;
		!dqOeLo_n && !$past(dqOeLo_n) |-> lowerByteStrobe != $past(lowerByteStrobe);
	endproperty
	a_tog: assert property (p_tog) else $error("Strobe did not toggle");
	property p_lane;
		dqOeLo_n == dqOeHi_n && lowerByteStrobe == upperByteStrobe;
	endproperty
	a_lane: assert property (p_lane) else $error("Byte lanes disagree");
	property p_noerr;
		!cmdError;
	endproperty
	a_noerr: assert property (p_noerr) else $error("Device refused a command");
	c_rdap: cover property (cmd == CMD_RD && autoPrechargeSelectBit);
	c_pc: cover property (|prechargeStart);
	c_bl8: cover property (burstLength8 && !dqOeLo_n);
endmodule

// ### sim/read_auto_precharge_timing_test.sv
`timescale 1ns/10ps
`include "rdap_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module read_auto_precharge_timing_test;
	logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, burstLength8, err, cmdError;
	logic [7:0] paddr, bankOpen, prechargeStart;
	logic [31:0] pwdata, prdata, r;
	int n_fail, cmp_count;
	// Op {ap, bank, op}: tight pairs force the controller to hold
	logic [5:0] seq [14] = '{6'h14, 6'h17, 6'h08, 6'h14, 6'h29, 6'h16, 6'h15, 6'h17, 6'h08, 6'h14, 6'h29, 6'h15, 6'h08, 6'h29};
	ddr_link_if link();
	rdap_ctrl_end rdap_ctrl_end_i(.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.ctrl));
	rdap_mem_end rdap_mem_end_i(.sys_clk(sys_clk), .reset(reset), .link(link.mem), .additiveLatency(3'h1),
		.casLatency(3'h3), .burstLength8(burstLength8), .bankOpen(bankOpen),
		.prechargeStart(prechargeStart), .cmdError(cmdError));
	rdap_link_monitor rdap_link_monitor_i(.sys_clk(sys_clk), .reset(reset), .cmd(link.cmd), .bank(link.bank),
		.autoPrechargeSelectBit(link.autoPrechargeSelectBit), .dqOut(link.dqOut), .dqOeLo_n(link.dqOeLo_n),
		.dqOeHi_n(link.dqOeHi_n), .lowerByteStrobe(link.lowerByteStrobe),
		.upperByteStrobe(link.upperByteStrobe), .burstLength8(burstLength8),
		.prechargeStart(prechargeStart), .cmdError(cmdError));
	////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// APB transfer; leading edge keeps release and next setup apart
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 300);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 300) begin
			n_fail++;
			print_verdict();
		end
	endtask
	// Poll status under a bound
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			xfer(1'b0, `REG_STATUS, 32'h0);
			n++;
		end while ((r & m) !== v && n < 60);
		`CHK(r & m, v)
		if (n >= 60 && (r & m) !== v)
			print_verdict();
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata, burstLength8} = {3'b100, 1'b0, 8'h0, 32'h0, 1'b0};
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		xfer(1'b0, `REG_CFG, 32'h0);
		`CHK(r, `CFG_RST)
		xfer(1'b0, `REG_TIMING, 32'h0);
		`CHK(r, `TIMING_RST)
		xfer(1'b0, 8'h14, 32'h0);
		`CHK({err, r}, 33'h100000000)
		xfer(1'b1, `REG_STATUS, 32'hffffffff);
		xfer(1'b0, `REG_STATUS, 32'h0);
		`CHK(r, 32'h0)
		for (int i = 0; i < 2; i++) begin
			if (i == 1) begin
				xfer(1'b1, `REG_CFG, 32'h131);
				burstLength8 <= 1'b1;
				xfer(1'b0, `REG_CFG, 32'h0);
				`CHK(r, 32'h131)
			end
			foreach (seq[k])
				xfer(1'b1, `REG_CMD, {26'h0, seq[k]});
			wait_st(32'h00ffff03, 32'h00002002);
			`CHK(bankOpen, 8'h20)
			xfer(1'b0, `REG_RDATA, 32'h0);
			`CHK(r[15:0], 16'h4000)
			xfer(1'b0, `REG_STATUS, 32'h0);
			`CHK(r[1], 1'b0)
			xfer(1'b1, `REG_CMD, 32'h17);
			wait_st(32'h00ffff03, 32'h0);
			`CHK(bankOpen, 8'h00)
		end
		print_verdict();
	end
endmodule
